/* File: design/ofd_decoder.sv */
// Operand field decoder between instruction fetch and the datapath.
// Assumes the opcode stage supplies class and flag class with each word,
// and that APB comes from a single master on pclk.
//
// Overview of operation
// - Access bit 0 uses fixed area, ignores bank
// - Access bit 1 uses bank register plus field
// - Destination bit picks accumulator or file register
// - Three-bit field selects one of eight bits
// - File field is address or pointer selector
// - Two-word move source from first word
// - Two-word move destination from second word
// - Literals extracted at 8, 12 or 20 bits
// - Table mode picks one of four pointer updates
// - 21-bit table pointer, 8-bit table latch
// - Fast bit saves or restores shadow copies
// - Relative branches signed, others absolute targets
// - Seven-bit unsigned offsets added to pointer base
// - Don't-care bits never affect decoding
// - Route five status flag updates by class
// - Lone second word executes as no-operation
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ofd_decoder #(
  parameter int PTR_W = 21,
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fetch side
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire ofd_pkg::ofd_class_t instr_class,
  input wire ofd_pkg::ofd_flag_class_t flag_class,
  input wire logic [PTR_W-1:0] pc_in,
  input wire logic [ADDR_W-1:0] index_base,
  // Table read return
  input wire logic tbl_rd_valid,
  input wire logic [7:0] tbl_rd_data,
  // Decoded operands
  output logic dec_valid,
  output logic dec_nop,
  output logic [ADDR_W-1:0] data_addr,
  output logic dest_file,
  output logic [2:0] bit_pos,
  output logic [7:0] bit_sel,
  output logic [1:0] ptr_sel,
  output logic [ADDR_W-1:0] mov_src,
  output logic [ADDR_W-1:0] mov_dst,
  output logic mov_go,
  output logic [19:0] literal,
  output ofd_pkg::ofd_lit_width_t literal_width,
  output logic [PTR_W-1:0] branch_target,
  output logic branch_go,
  output logic shadow_save,
  output logic shadow_restore,
  output logic tbl_go,
  output logic tbl_write,
  output logic [PTR_W-1:0] tbl_addr,
  output logic [6:0] idx_src_off,
  output logic [6:0] idx_dst_off,
  output logic [ADDR_W-1:0] idx_src_addr,
  output logic [ADDR_W-1:0] idx_dst_addr,
  output logic [4:0] flag_we
);

  // ************************************************
  // Sequencer and operand registers
  // ************************************************
  typedef enum logic {OFD_ST_FIRST, OFD_ST_SECOND} ofd_state_t;

  ofd_state_t state_reg, state_next;
  ofd_pkg::ofd_class_t pend_class_reg, pend_class_next;
  logic [15:0] pend_word_reg, pend_word_next;
  logic orphan_reg, orphan_next;
  logic [3:0] bank_reg, bank_next;
  logic [3:0] shadow_bank_reg, shadow_bank_next;
  logic [7:0] tbl_latch_reg, tbl_latch_next;

  logic dec_valid_next, dec_nop_next, dest_file_next, mov_go_next, branch_go_next;
  logic shadow_save_next, shadow_restore_next, tbl_go_next, tbl_write_next;
  logic [ADDR_W-1:0] data_addr_next, mov_src_next, mov_dst_next;
  logic [ADDR_W-1:0] idx_src_addr_next, idx_dst_addr_next;
  logic [2:0] bit_pos_next;
  logic [7:0] bit_sel_next;
  logic [1:0] ptr_sel_next;
  logic [19:0] literal_next;
  ofd_pkg::ofd_lit_width_t literal_width_next;
  logic [PTR_W-1:0] branch_target_next, tbl_addr_next;
  logic [6:0] idx_src_off_next, idx_dst_off_next;
  logic [4:0] flag_we_next, flag_we_raw;

  // Table pointer interface
  logic tbl_step, tbl_load;
  logic [PTR_W-1:0] tbl_ptr, tbl_access;
  ofd_pkg::ofd_tbl_mode_t tbl_mode;

  // APB decode
  logic apb_wr, apb_rd_ok;

  function automatic logic [ADDR_W-1:0] ofd_file_addr(input logic a, input logic [3:0] bank,
                                                       input logic [7:0] f);
    // Access bit clear ignores the bank register entirely
    return a ? ADDR_W'({bank, f}) : ADDR_W'({ofd_pkg::OFD_ACCESS_BANK, f});
  endfunction

  // Only the mode bits reach the pointer; bit 2 picks read or write, the rest of the word is don't-care
  assign tbl_mode = ofd_pkg::ofd_tbl_mode_t'(instr_word[1:0]);

  ofd_table_ptr #(
    .PTR_W(PTR_W)
  ) u_table_ptr (
    .pclk(pclk),
    .presetn(presetn),
    .step(tbl_step),
    .mode(tbl_mode),
    .load(tbl_load),
    .load_val(pwdata[PTR_W-1:0]),
    .ptr(tbl_ptr),
    .access_addr(tbl_access)
  );

  ofd_flag_router u_flag_router (
    .flag_class(flag_class),
    .flag_we(flag_we_raw)
  );

  // ************************************************
  // Field extraction
  // ************************************************
  always_comb begin
    state_next = state_reg;
    pend_class_next = pend_class_reg;
    pend_word_next = pend_word_reg;
    orphan_next = 1'b0;
    shadow_bank_next = shadow_bank_reg;
    dec_valid_next = 1'b0;
    dec_nop_next = 1'b0;
    mov_go_next = 1'b0;
    branch_go_next = 1'b0;
    shadow_save_next = 1'b0;
    shadow_restore_next = 1'b0;
    tbl_go_next = 1'b0;
    tbl_step = 1'b0;
    // Operands hold between instructions so the datapath sees them stable
    dest_file_next = dest_file;
    data_addr_next = data_addr;
    bit_pos_next = bit_pos;
    bit_sel_next = bit_sel;
    ptr_sel_next = ptr_sel;
    mov_src_next = mov_src;
    mov_dst_next = mov_dst;
    literal_next = literal;
    literal_width_next = literal_width;
    branch_target_next = branch_target;
    tbl_write_next = tbl_write;
    tbl_addr_next = tbl_addr;
    idx_src_off_next = idx_src_off;
    idx_dst_off_next = idx_dst_off;
    idx_src_addr_next = idx_src_addr;
    idx_dst_addr_next = idx_dst_addr;
    flag_we_next = flag_we;
    if (instr_valid) begin
      dec_valid_next = 1'b1;
      flag_we_next = flag_we_raw;
      if (state_reg == OFD_ST_SECOND && instr_word[15:12] == ofd_pkg::OFD_SECOND_TAG) begin
        state_next = OFD_ST_FIRST;
        unique case (pend_class_reg)
          ofd_pkg::OFD_CL_MOVE2: begin
            mov_src_next = ADDR_W'(pend_word_reg[11:0]);
            mov_dst_next = ADDR_W'(instr_word[11:0]);
            mov_go_next = 1'b1;
          end
          ofd_pkg::OFD_CL_CALL, ofd_pkg::OFD_CL_GOTO: begin
            literal_next = {instr_word[11:0], pend_word_reg[7:0]};
            literal_width_next = ofd_pkg::OFD_LW_20;
            branch_target_next = PTR_W'({instr_word[11:0], pend_word_reg[7:0], 1'b0});
            branch_go_next = 1'b1;
            if (pend_class_reg == ofd_pkg::OFD_CL_CALL && pend_word_reg[ofd_pkg::OFD_S_CALL_BIT]) begin
              shadow_save_next = 1'b1;
              shadow_bank_next = bank_reg;
            end
          end
          ofd_pkg::OFD_CL_PTR_LOAD: begin
            ptr_sel_next = pend_word_reg[ofd_pkg::OFD_PTR_SEL_LSB +: 2];
            literal_next = 20'({pend_word_reg[3:0], instr_word[7:0]});
            literal_width_next = ofd_pkg::OFD_LW_12;
          end
          default: begin
            // Indexed move: source offset first word, destination second word
            idx_src_off_next = pend_word_reg[6:0];
            idx_dst_off_next = instr_word[6:0];
            idx_src_addr_next = index_base + ADDR_W'(pend_word_reg[6:0]);
            idx_dst_addr_next = index_base + ADDR_W'(instr_word[6:0]);
          end
        endcase
      end else begin
        // A word tagged as a second word arriving on its own does nothing
        orphan_next = state_reg == OFD_ST_SECOND;
        state_next = OFD_ST_FIRST;
        if (state_reg == OFD_ST_FIRST && instr_word[15:12] == ofd_pkg::OFD_SECOND_TAG &&
            instr_class == ofd_pkg::OFD_CL_NOP) begin
          dec_nop_next = 1'b1;
          flag_we_next = 5'h00;
        end else begin
          unique case (instr_class)
            ofd_pkg::OFD_CL_NOP: begin
              dec_nop_next = 1'b1;
              flag_we_next = 5'h00;
            end
            ofd_pkg::OFD_CL_BYTE_FD, ofd_pkg::OFD_CL_BYTE_F: begin
              data_addr_next = ofd_file_addr(instr_word[ofd_pkg::OFD_A_BIT], bank_reg,
                                             instr_word[7:0]);
              // Classes without a d field always write the file register
              dest_file_next = (instr_class == ofd_pkg::OFD_CL_BYTE_F) ||
                               instr_word[ofd_pkg::OFD_D_BIT];
            end
            ofd_pkg::OFD_CL_BIT: begin
              data_addr_next = ofd_file_addr(instr_word[ofd_pkg::OFD_A_BIT], bank_reg,
                                             instr_word[7:0]);
              bit_pos_next = instr_word[ofd_pkg::OFD_B_LSB +: 3];
              bit_sel_next = 8'h01 << instr_word[ofd_pkg::OFD_B_LSB +: 3];
              dest_file_next = 1'b1;
            end
            ofd_pkg::OFD_CL_LIT8: begin
              literal_next = 20'(instr_word[7:0]);
              literal_width_next = ofd_pkg::OFD_LW_8;
            end
            ofd_pkg::OFD_CL_BRA11: begin
              literal_next = 20'(instr_word[10:0]);
              literal_width_next = ofd_pkg::OFD_LW_NONE;
              branch_target_next = pc_in + PTR_W'({{(PTR_W-12){instr_word[10]}}, instr_word[10:0], 1'b0});
              branch_go_next = 1'b1;
            end
            ofd_pkg::OFD_CL_BR8: begin
              literal_next = 20'(instr_word[7:0]);
              literal_width_next = ofd_pkg::OFD_LW_NONE;
              branch_target_next = pc_in + PTR_W'({{(PTR_W-9){instr_word[7]}}, instr_word[7:0], 1'b0});
              branch_go_next = 1'b1;
            end
            ofd_pkg::OFD_CL_RET: begin
              if (instr_word[ofd_pkg::OFD_S_RET_BIT]) begin
                shadow_restore_next = 1'b1;
              end
            end
            ofd_pkg::OFD_CL_TABLE: begin
              tbl_step = 1'b1;
              tbl_go_next = 1'b1;
              tbl_write_next = instr_word[ofd_pkg::OFD_TBL_WR_BIT];
              tbl_addr_next = tbl_access;
            end
            default: begin
              // Two-word instructions wait for their second word
              state_next = OFD_ST_SECOND;
              pend_class_next = instr_class;
              pend_word_next = instr_word;
              dec_valid_next = 1'b0;
            end
          endcase
        end
      end
    end
  end

  // ************************************************
  // Register bus
  // ************************************************
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    prdata = 32'h00000000;
    apb_rd_ok = 1'b1;
    unique case (paddr)
      ofd_pkg::OFD_OFF_BANK: prdata = 32'(bank_reg);
      ofd_pkg::OFD_OFF_TABLE_POINTER: prdata = 32'(tbl_ptr);
      ofd_pkg::OFD_OFF_TBLLAT: prdata = 32'(tbl_latch_reg);
      ofd_pkg::OFD_OFF_STATUS: prdata = 32'({orphan_reg, state_reg == OFD_ST_SECOND});
      ofd_pkg::OFD_OFF_SHADOW: prdata = 32'(shadow_bank_reg);
      default: apb_rd_ok = 1'b0;
    endcase
    pslverr = psel && penable && !apb_rd_ok;
  end

  always_comb begin
    tbl_load = apb_wr && paddr == ofd_pkg::OFD_OFF_TABLE_POINTER;
    bank_next = bank_reg;
    if (shadow_restore) begin
      bank_next = shadow_bank_reg;
    end
    if (apb_wr && paddr == ofd_pkg::OFD_OFF_BANK) begin
      bank_next = pwdata[3:0];
    end
    tbl_latch_next = tbl_latch_reg;
    // Returning program data wins over a software write in the same cycle
    if (apb_wr && paddr == ofd_pkg::OFD_OFF_TBLLAT) begin
      tbl_latch_next = pwdata[7:0];
    end
    if (tbl_rd_valid) begin
      tbl_latch_next = tbl_rd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= OFD_ST_FIRST;
      pend_class_reg <= ofd_pkg::OFD_CL_NOP;
      pend_word_reg <= 16'h0000;
      orphan_reg <= 1'b0;
      bank_reg <= ofd_pkg::OFD_RST_BANK;
      shadow_bank_reg <= ofd_pkg::OFD_RST_BANK;
      tbl_latch_reg <= ofd_pkg::OFD_RST_TBLLAT;
      dec_valid <= 1'b0;
      dec_nop <= 1'b0;
      data_addr <= '0;
      dest_file <= 1'b0;
      bit_pos <= 3'h0;
      bit_sel <= 8'h00;
      ptr_sel <= 2'h0;
      mov_src <= '0;
      mov_dst <= '0;
      mov_go <= 1'b0;
      literal <= 20'h00000;
      literal_width <= ofd_pkg::OFD_LW_NONE;
      branch_target <= '0;
      branch_go <= 1'b0;
      shadow_save <= 1'b0;
      shadow_restore <= 1'b0;
      tbl_go <= 1'b0;
      tbl_write <= 1'b0;
      tbl_addr <= '0;
      idx_src_off <= 7'h00;
      idx_dst_off <= 7'h00;
      idx_src_addr <= '0;
      idx_dst_addr <= '0;
      flag_we <= 5'h00;
    end else begin
      state_reg <= state_next;
      pend_class_reg <= pend_class_next;
      pend_word_reg <= pend_word_next;
      orphan_reg <= orphan_next;
      bank_reg <= bank_next;
      shadow_bank_reg <= shadow_bank_next;
      tbl_latch_reg <= tbl_latch_next;
      dec_valid <= dec_valid_next;
      dec_nop <= dec_nop_next;
      data_addr <= data_addr_next;
      dest_file <= dest_file_next;
      bit_pos <= bit_pos_next;
      bit_sel <= bit_sel_next;
      ptr_sel <= ptr_sel_next;
      mov_src <= mov_src_next;
      mov_dst <= mov_dst_next;
      mov_go <= mov_go_next;
      literal <= literal_next;
      literal_width <= literal_width_next;
      branch_target <= branch_target_next;
      branch_go <= branch_go_next;
      shadow_save <= shadow_save_next;
      shadow_restore <= shadow_restore_next;
      tbl_go <= tbl_go_next;
      tbl_write <= tbl_write_next;
      tbl_addr <= tbl_addr_next;
      idx_src_off <= idx_src_off_next;
      idx_dst_off <= idx_dst_off_next;
      idx_src_addr <= idx_src_addr_next;
      idx_dst_addr <= idx_dst_addr_next;
      flag_we <= flag_we_next;
    end
  end

endmodule

/* File: design/ofd_flag_router.sv */
// Flag-affect class to per-flag write enables.
// Assumes the class arrives with the instruction word it belongs to.
`timescale 1ns/1ps
module ofd_flag_router (
  // Class in
  input wire ofd_pkg::ofd_flag_class_t flag_class,
  // Enables out: carry, nibble carry, zero, signed range, negative
  output logic [4:0] flag_we
);

  function automatic logic [4:0] ofd_flag_mask(input ofd_pkg::ofd_flag_class_t fc);
    logic [4:0] m;
    m = 5'h00;
    unique case (fc)
      ofd_pkg::OFD_FL_NONE: m = 5'h00;
      ofd_pkg::OFD_FL_ALL: m = 5'h1F;
      ofd_pkg::OFD_FL_ZN: begin
        m[ofd_pkg::OFD_FLG_ZERO] = 1'b1;
        m[ofd_pkg::OFD_FLG_NEG] = 1'b1;
      end
      ofd_pkg::OFD_FL_Z: m[ofd_pkg::OFD_FLG_ZERO] = 1'b1;
      ofd_pkg::OFD_FL_CZN: begin
        m[ofd_pkg::OFD_FLG_CARRY] = 1'b1;
        m[ofd_pkg::OFD_FLG_ZERO] = 1'b1;
        m[ofd_pkg::OFD_FLG_NEG] = 1'b1;
      end
      default: m = 5'h00;
    endcase
    return m;
  endfunction

  always_comb begin
    flag_we = ofd_flag_mask(flag_class);
  end

endmodule

/* File: design/ofd_table_ptr.sv */
// Table pointer with its four update modes around an access.
// Assumes step is a one-cycle pulse per table instruction.
`timescale 1ns/1ps
module ofd_table_ptr #(
  parameter int PTR_W = 21
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic step,
  input wire ofd_pkg::ofd_tbl_mode_t mode,
  input wire logic load,
  input wire logic [PTR_W-1:0] load_val,
  // State
  output logic [PTR_W-1:0] ptr,
  output logic [PTR_W-1:0] access_addr
);

  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] ptr_next;

  always_comb begin
    access_addr = (mode == ofd_pkg::OFD_TBL_PRE_INC) ? ptr_reg + 1'b1 : ptr_reg;
    ptr_next = ptr_reg;
    if (load) begin
      ptr_next = load_val;
    end else if (step) begin
      unique case (mode)
        ofd_pkg::OFD_TBL_KEEP: ptr_next = ptr_reg;
        ofd_pkg::OFD_TBL_POST_INC: ptr_next = ptr_reg + 1'b1;
        ofd_pkg::OFD_TBL_POST_DEC: ptr_next = ptr_reg - 1'b1;
        ofd_pkg::OFD_TBL_PRE_INC: ptr_next = ptr_reg + 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= PTR_W'(ofd_pkg::OFD_RST_TABLE_POINTER);
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  assign ptr = ptr_reg;

endmodule

/* File: include/ofd_pkg.sv */
// Shared constants and types of the operand field decoder.
// Assumes a 16-bit instruction word and a 32-bit APB register bus.
package ofd_pkg;

  // ************************************************
  // Instruction and flag classes from the opcode stage
  // ************************************************
  typedef enum logic [3:0] {
    OFD_CL_NOP, OFD_CL_BYTE_FD, OFD_CL_BYTE_F, OFD_CL_BIT, OFD_CL_LIT8,
    OFD_CL_PTR_LOAD, OFD_CL_MOVE2, OFD_CL_CALL, OFD_CL_GOTO, OFD_CL_BRA11,
    OFD_CL_BR8, OFD_CL_RET, OFD_CL_TABLE, OFD_CL_INDEXED
  } ofd_class_t;

  typedef enum logic [2:0] {
    OFD_FL_NONE, OFD_FL_ALL, OFD_FL_ZN, OFD_FL_Z, OFD_FL_CZN
  } ofd_flag_class_t;

  // Order follows the two-bit mode field encoding
  typedef enum logic [1:0] {
    OFD_TBL_KEEP, OFD_TBL_POST_INC, OFD_TBL_POST_DEC, OFD_TBL_PRE_INC
  } ofd_tbl_mode_t;

  typedef enum logic [1:0] {
    OFD_LW_NONE, OFD_LW_8, OFD_LW_12, OFD_LW_20
  } ofd_lit_width_t;

  // ************************************************
  // Instruction field positions
  // ************************************************
  localparam int OFD_A_BIT = 8;
  localparam int OFD_D_BIT = 9;
  localparam int OFD_B_LSB = 9;
  localparam int OFD_S_CALL_BIT = 8;
  localparam int OFD_S_RET_BIT = 0;
  localparam int OFD_PTR_SEL_LSB = 4;
  localparam int OFD_TBL_WR_BIT = 2;
  localparam logic [3:0] OFD_SECOND_TAG = 4'hF;

  // Flag write-enable bit positions
  localparam int OFD_FLG_CARRY = 0;
  localparam int OFD_FLG_NIBBLE = 1;
  localparam int OFD_FLG_ZERO = 2;
  localparam int OFD_FLG_SIGNED = 3;
  localparam int OFD_FLG_NEG = 4;

  // ************************************************
  // Register map and reset values
  // ************************************************
  localparam logic [11:0] OFD_OFF_BANK = 12'h000;
  localparam logic [11:0] OFD_OFF_TABLE_POINTER = 12'h004;
  localparam logic [11:0] OFD_OFF_TBLLAT = 12'h008;
  localparam logic [11:0] OFD_OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFD_OFF_SHADOW = 12'h010;
  localparam logic [3:0] OFD_RST_BANK = 4'h0;
  localparam logic [20:0] OFD_RST_TABLE_POINTER = 21'h000000;
  localparam logic [7:0] OFD_RST_TBLLAT = 8'h00;
  localparam logic [3:0] OFD_ACCESS_BANK = 4'h0;

endpackage

/* File: testbench/ofd_monitor.sv */
// Concurrent checks on the operand outputs of the decoder.
// Assumes it is bound into ofd_decoder and sees only its ports.
`timescale 1ns/1ps
module ofd_monitor #(
  parameter int PTR_W = 21,
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fetch side
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire ofd_pkg::ofd_class_t instr_class,
  input wire ofd_pkg::ofd_flag_class_t flag_class,
  input wire logic [PTR_W-1:0] pc_in,
  // Decoded operands
  input wire logic dec_valid,
  input wire logic [ADDR_W-1:0] data_addr,
  input wire logic dest_file,
  input wire logic [7:0] bit_sel,
  input wire logic [ADDR_W-1:0] mov_src,
  input wire logic [ADDR_W-1:0] mov_dst,
  input wire logic mov_go,
  input wire logic [PTR_W-1:0] branch_target,
  input wire logic [4:0] flag_we
);
  logic sw;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A word that cannot be a second word, so it starts an instruction
  assign sw = instr_valid && instr_word[15:12] != ofd_pkg::OFD_SECOND_TAG;
  // ****
  // Operand checks
  // ****
  chk_fixed_area:
    assert property (sw && instr_class == ofd_pkg::OFD_CL_BYTE_FD && !instr_word[8] |=> dec_valid && data_addr == {ofd_pkg::OFD_ACCESS_BANK, $past(instr_word[7:0])})
    else $error("fixed area address wrong");
  chk_banked_low:
    assert property (sw && instr_class == ofd_pkg::OFD_CL_BYTE_FD && instr_word[8] |=> data_addr[7:0] == $past(instr_word[7:0]))
    else $error("banked address low byte wrong");
  chk_dest_steer:
    assert property (sw && instr_class == ofd_pkg::OFD_CL_BYTE_FD |=> dest_file == $past(instr_word[9]))
    else $error("destination select wrong");
  chk_bit_mask:
    assert property (sw && instr_class == ofd_pkg::OFD_CL_BIT |=> bit_sel == 8'h01 << $past(instr_word[11:9]))
    else $error("bit mask wrong");
  chk_move_pair:
    assert property (sw && instr_class == ofd_pkg::OFD_CL_MOVE2 ##1 instr_valid && !sw |=> mov_go && mov_src == $past(instr_word[11:0], 2) && mov_dst == $past(instr_word[11:0]))
    else $error("move addresses wrong");
  chk_move_waits:
    assert property (sw && instr_class == ofd_pkg::OFD_CL_MOVE2 |=> !dec_valid && !mov_go)
    else $error("move decoded before its second word");
  chk_rel_branch:
    assert property (sw && instr_class == ofd_pkg::OFD_CL_BRA11 |=> branch_target == $past(pc_in) + {{9{$past(instr_word[10])}}, $past(instr_word[10:0]), 1'b0})
    else $error("relative target wrong");
  chk_flags_all:
    assert property (sw && flag_class == ofd_pkg::OFD_FL_ALL |=> flag_we == 5'h1F)
    else $error("flag enables wrong");
endmodule
bind ofd_decoder ofd_monitor #(.PTR_W(PTR_W), .ADDR_W(ADDR_W)) u_ofd_monitor (
  .pclk, .presetn, .instr_valid, .instr_word, .instr_class, .flag_class, .pc_in, .dec_valid,
  .data_addr, .dest_file, .bit_sel, .mov_src, .mov_dst, .mov_go, .branch_target, .flag_we
);

/* File: testbench/tb.sv */
// Self-checking bench of the operand field decoder over APB and the fetch side.
// Assumes zero-wait APB and one-cycle decode; the fast return runs last.
`timescale 1ns/1ps
module tb;
  typedef struct {int sel; logic [31:0] v;} ofd_exp_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0, tbl_rd_valid = 0;
  logic [11:0] paddr = 0, index_base = 0;
  logic [31:0] pwdata = 0, r, lfsr = 32'hFE81B981;
  logic [15:0] instr_word = 0;
  logic [20:0] pc_in = 0;
  logic [7:0] tbl_rd_data = 0;
  ofd_pkg::ofd_class_t instr_class = ofd_pkg::OFD_CL_NOP;
  ofd_pkg::ofd_flag_class_t flag_class = ofd_pkg::OFD_FL_NONE;
  logic [31:0] prdata;
  logic pready, pslverr, dec_valid, dec_nop, dest_file, tbl_write;
  logic [11:0] data_addr, mov_src, mov_dst, idx_src_addr, idx_dst_addr;
  logic [7:0] bit_sel;
  logic [19:0] literal;
  logic [20:0] branch_target, tbl_addr;
  logic [4:0] flag_we;
  logic [4:0] fexp [5] = '{5'h00, 5'h1F, 5'h14, 5'h04, 5'h15};
  logic [20:0] pexp [4] = '{21'h1FFFFF, 21'h000000, 21'h1FFFFE, 21'h000000};
  int fails = 0, n_compared = 0;
  ofd_exp_t q[$];
  ofd_decoder dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .instr_valid, .instr_word, .instr_class, .flag_class, .pc_in, .index_base, .tbl_rd_valid, .tbl_rd_data,
    .dec_valid, .dec_nop, .data_addr, .dest_file, .bit_pos(), .bit_sel, .ptr_sel(), .mov_src, .mov_dst,
    .mov_go(), .literal, .literal_width(), .branch_target, .branch_go(), .shadow_save(), .shadow_restore(),
    .tbl_go(), .tbl_write, .tbl_addr, .idx_src_off(), .idx_dst_off(), .idx_src_addr, .idx_dst_addr, .flag_we
  );
  always #20 pclk = ~pclk;
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (q.size() != 0) fails++;
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic put(input int s, input logic [31:0] v);
    q.push_back('{s, v});
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] v);
    put(7, v);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic issue(input logic [15:0] w, input ofd_pkg::ofd_class_t c,
                       input ofd_pkg::ofd_flag_class_t f = ofd_pkg::OFD_FL_NONE);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    instr_class <= c;
    flag_class <= f;
  endtask
  task automatic idle();
    @(posedge pclk);
    instr_valid <= 1'b0;
  endtask
  // Read mid-cycle, after every edge update has landed
  always @(negedge pclk) begin
    ofd_exp_t e;
    if (presetn && (dec_valid || (psel && penable && !pwrite && pready))) begin
      if (q.size() == 0) e = '{-1, 32'h0};
      else e = q.pop_front();
      case (e.sel)
        -1: check(32'h1, 32'h0);
        0: check(32'(data_addr), e.v);
        1: check({26'h0, dest_file, flag_we}, e.v);
        2: check({24'h0, bit_sel}, e.v);
        3: check({8'h0, mov_src, mov_dst}, e.v);
        4: check({12'h0, literal}, e.v);
        5: check({11'h0, branch_target}, e.v);
        6: check({8'h0, idx_src_addr, idx_dst_addr}, e.v);
        7: check(prdata, e.v);
        8: check({31'h0, dec_nop}, e.v);
        9: check({10'h0, tbl_write, tbl_addr}, e.v);
        default: ;
      endcase
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values; unmapped word reads zero
    for (int i = 0; i < 6; i++) rd(12'(4 * i), 32'h0);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      apb(1'b1, ofd_pkg::OFD_OFF_BANK, {28'h0, r[3:0]});
      put(0, 32'({(r[8] ? r[3:0] : 4'h0), r[7:0]}));
      issue({7'h12, r[8:0]}, ofd_pkg::OFD_CL_BYTE_FD);
      idle();
    end
    // Back-to-back words, all flag classes
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      put(1, {26'h0, i[0], fexp[i]});
      issue({6'h05, i[0], 1'b0, r[7:0]}, ofd_pkg::OFD_CL_BYTE_FD, ofd_pkg::ofd_flag_class_t'(i));
    end
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      put(2, 32'h1 << i);
      issue({4'h8, i[2:0], r[8:0]}, ofd_pkg::OFD_CL_BIT);
    end
    for (int i = 0; i < 2; i++) begin
      r = rnd();
      put(3, {8'h0, r[23:0]});
      issue({4'hC, r[23:12]}, ofd_pkg::OFD_CL_MOVE2);
      issue({4'hF, r[11:0]}, ofd_pkg::OFD_CL_NOP);
    end
    r = rnd();
    put(4, {24'h0, r[7:0]});
    issue({8'h0E, r[7:0]}, ofd_pkg::OFD_CL_LIT8);
    put(4, {20'h0, r[19:8]});
    issue({10'h3B8, r[21:20], r[19:16]}, ofd_pkg::OFD_CL_PTR_LOAD);
    issue({8'hF0, r[15:8]}, ofd_pkg::OFD_CL_NOP);
    // A move cut short by a new word, then a lone second word
    issue({4'hC, r[11:0]}, ofd_pkg::OFD_CL_MOVE2);
    put(0, {24'h0, r[7:0]});
    issue({7'h12, 1'b0, r[7:0]}, ofd_pkg::OFD_CL_BYTE_FD);
    put(8, 32'h1);
    issue({4'hF, r[31:20]}, ofd_pkg::OFD_CL_NOP);
    index_base <= r[11:0];
    put(6, {8'h0, 12'(r[11:0] + r[6:0]), 12'(r[11:0] + r[22:16])});
    issue({9'h0, r[6:0]}, ofd_pkg::OFD_CL_INDEXED);
    issue({9'h1E0, r[22:16]}, ofd_pkg::OFD_CL_NOP);
    for (int i = 0; i < 2; i++) begin
      r = rnd();
      idle();
      pc_in <= r[31:11];
      put(5, {11'h0, 21'(r[31:11] + (i == 0 ? {{9{r[10]}}, r[10:0], 1'b0} : {{12{r[7]}}, r[7:0], 1'b0}))});
      if (i == 0) issue({5'h1A, r[10:0]}, ofd_pkg::OFD_CL_BRA11);
      else issue({8'hE2, r[7:0]}, ofd_pkg::OFD_CL_BR8);
    end
    idle();
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, ofd_pkg::OFD_OFF_TABLE_POINTER, 32'h001FFFFF);
      put(9, {10'h0, m[0], (m == 3 ? 21'h0 : 21'h1FFFFF)});
      issue({13'h0, m[0], m[1:0]}, ofd_pkg::OFD_CL_TABLE);
      idle();
      rd(ofd_pkg::OFD_OFF_TABLE_POINTER, {11'h0, pexp[m]});
    end
    r = rnd();
    @(posedge pclk);
    tbl_rd_valid <= 1'b1;
    tbl_rd_data <= r[7:0];
    @(posedge pclk);
    tbl_rd_valid <= 1'b0;
    rd(ofd_pkg::OFD_OFF_TBLLAT, {24'h0, r[7:0]});
    // Fast call saves the bank; only the fast return brings it back
    apb(1'b1, ofd_pkg::OFD_OFF_BANK, 32'h5);
    put(5, {11'h0, r[27:8], 1'b0});
    issue({8'hED, r[15:8]}, ofd_pkg::OFD_CL_CALL);
    issue({4'hF, r[27:16]}, ofd_pkg::OFD_CL_NOP);
    idle();
    apb(1'b1, ofd_pkg::OFD_OFF_BANK, 32'h9);
    rd(ofd_pkg::OFD_OFF_SHADOW, 32'h5);
    for (int s = 0; s < 2; s++) begin
      put(15, 32'h0);
      issue({15'h0009, s[0]}, ofd_pkg::OFD_CL_RET);
      idle();
      rd(ofd_pkg::OFD_OFF_BANK, s ? 32'h5 : 32'h9);
    end
    repeat (3) @(posedge pclk);
    conclude();
  end
endmodule
